/* verilog/spcm_map.vh */
// register offsets, field positions and reset values of the serial port control block
`ifndef SPCM_MAP_VH
`define SPCM_MAP_VH

`define SPCM_OFF_CMD        8'h00
`define SPCM_OFF_MODE       8'h04
`define SPCM_OFF_STATUS     8'h08
`define SPCM_OFF_TXHOLD     8'h0c
`define SPCM_OFF_WPROT      8'h10
`define SPCM_OFF_ERRINJ     8'h14

`define SPCM_CMD_RXRST      2
`define SPCM_CMD_TXRST      3
`define SPCM_CMD_RXON       4
`define SPCM_CMD_RXOFF      5
`define SPCM_CMD_TXON       6
`define SPCM_CMD_TXOFF      7
`define SPCM_CMD_STCLR      8
`define SPCM_CMD_BRKSTART   9
`define SPCM_CMD_BRKSTOP    10
`define SPCM_CMD_TOSTART    11
`define SPCM_CMD_SENDADDR   12
`define SPCM_CMD_NACKCLR    14
`define SPCM_CMD_TOREARM    15
`define SPCM_CMD_REQASSERT  18
`define SPCM_CMD_REQDEASSERT 19
`define SPCM_CMD_LINABORT   20
`define SPCM_CMD_LINWAKE    21

`define SPCM_MODE_MASK      32'h001fffff
`define SPCM_MODE_RESET     32'h00000000
`define SPCM_MODE_SPI_M     4'he
`define SPCM_MODE_SPI_S     4'hf
`define SPCM_CLKSRC_EXT     2'h3

`define SPCM_GUARD_MIN_BITS 8'h0c
`define SPCM_TO_RELOAD      16'h0100

`endif

/* verilog/spcm_top.v */
// serial port command strobes, mode register and derived line controls
// Function
// R1 - wakeup command starts lin wakeup
// R2 - abort command ends lin transmission
// R3 - deassert raises rts or releases select
// R4 - assert lowers rts or forces select
// R5 - rearm reloads timeout, clears timeout flag
// R6 - start timeout waits next char, clears flag
// R7 - send address marks next held char
// R8 - stop break then guard ones
// R9 - start break after transmit drains
// R10 - status clear wipes error flags
// R11 - enable only without simultaneous disable
// R12 - reset commands reset tx or rx
// R13 - mode writes blocked under protection
// R14 - flag_a inhibit and flag_a clear
// R15 - oversampling 16 or 8
// R16 - clock pin driven unless external
// R17 - character length 5 to 9
// R18 - bit order or clock idle level
// R19 - channel loop selection
// R20 - stop bits, reserved codes flagged
// R21 - parity selection decoded
// R22 - async/sync or spi phase
`timescale 1ns/1ps
`include "spcm_map.vh"

module spcm_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        rx_char_done,
    input  wire        tx_drained,
    input  wire        tx_bit_tick,
    input  wire        flag_a_seen,
    input  wire        timeout_tick,
    output reg         tx_enabled_q,
    output reg         rx_enabled_q,
    output reg         tx_reset_q,
    output reg         rx_reset_q,
    output reg         lin_wakeup_q,
    output reg         lin_abort_q,
    output reg         rts_q,
    output reg         break_active_q,
    output reg         guard_active_q,
    output reg         addr_mark_q,
    output reg         tx_load_q,
    output reg  [8:0]  tx_char_q,
    output reg         clk_pin_oe_q,
    output reg         clk_idle_q,
    output reg         msb_first_q,
    output reg         over8_q,
    output reg  [3:0]  char_bits_q,
    output reg  [1:0]  loop_mode_q,
    output reg  [1:0]  stop_code_q,
    output reg         stop_reserved_q,
    output reg  [2:0]  parity_mode_q,
    output reg         sync_or_phase_q,
    output reg         flag_a_enable_q
);

    // parity_mode_q: 0 even,1 odd,2 space,3 mark,4 none,5 multidrop
    reg  [31:0] mode_q;
    reg         write_protect_on_q;
    reg  [7:0]  err_q;
    reg         timeout_flag_q;
    reg         flag_a_flag_q;
    reg         to_run_q;
    reg         to_wait_q;
    reg  [15:0] to_cnt_q;
    reg         send_address_q;
    reg         brk_pend_q;
    reg  [7:0]  guard_cnt_q;
    reg  [7:0]  timeguard_length_q;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_have_q;
    reg         w_have_q;

    function is_spi;
        input [3:0] m;
        begin
            is_spi = (m == `SPCM_MODE_SPI_M) || (m == `SPCM_MODE_SPI_S);
        end
    endfunction

    wire        wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
    // exact match: an unaligned command write is refused and must do nothing
    wire        wr_cmd = wr_go && (awaddr_q == `SPCM_OFF_CMD);
    wire [31:0] cmd    = wr_cmd ? wdata_q : 32'h00000000;
    wire        spi    = is_spi(mode_q[3:0]);
    wire        spi_m  = (mode_q[3:0] == `SPCM_MODE_SPI_M);

    // axi write side: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped offsets and protected mode writes answer slverr
                if (awaddr_q > `SPCM_OFF_ERRINJ || awaddr_q[1:0] != 2'h0 ||
                    (awaddr_q == `SPCM_OFF_MODE && write_protect_on_q))
                    s_axi_bresp <= 2'h2;
                else
                    s_axi_bresp <= 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read side
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `SPCM_OFF_CMD:    s_axi_rdata <= 32'h00000000;
                    `SPCM_OFF_MODE:   s_axi_rdata <= mode_q;
                    `SPCM_OFF_STATUS: s_axi_rdata <= {16'h0000, tx_enabled_q,
                        rx_enabled_q, break_active_q, guard_active_q, timeout_flag_q,
                        flag_a_flag_q, to_run_q, to_wait_q, err_q};
                    `SPCM_OFF_TXHOLD: s_axi_rdata <= 32'h00000000;
                    `SPCM_OFF_WPROT:  s_axi_rdata <= {24'h000000, timeguard_length_q[6:0],
                        write_protect_on_q};
                    `SPCM_OFF_ERRINJ: s_axi_rdata <= 32'h00000000;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // mode register, protection and timeguard
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_q             <= `SPCM_MODE_RESET;
            write_protect_on_q <= 1'b0;
            timeguard_length_q <= 8'h00;
        end else if (wr_go && wstrb_q == 4'hf) begin
            if (awaddr_q == `SPCM_OFF_MODE && !write_protect_on_q)
                mode_q <= wdata_q & `SPCM_MODE_MASK; // R13
            if (awaddr_q == `SPCM_OFF_WPROT) begin
                write_protect_on_q <= wdata_q[0];
                timeguard_length_q <= {1'b0, wdata_q[7:1]};
            end
        end
    end

    // enables, resets and one-cycle command pulses
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_enabled_q <= 1'b0;
            rx_enabled_q <= 1'b0;
            tx_reset_q   <= 1'b0;
            rx_reset_q   <= 1'b0;
            lin_wakeup_q <= 1'b0;
            lin_abort_q  <= 1'b0;
            rts_q        <= 1'b1;
        end else begin
            if (cmd[`SPCM_CMD_TXOFF])
                tx_enabled_q <= 1'b0; // R11
            else if (cmd[`SPCM_CMD_TXON])
                tx_enabled_q <= 1'b1; // R11
            if (cmd[`SPCM_CMD_RXOFF])
                rx_enabled_q <= 1'b0; // R11
            else if (cmd[`SPCM_CMD_RXON])
                rx_enabled_q <= 1'b1; // R11
            tx_reset_q   <= cmd[`SPCM_CMD_TXRST]; // R12
            rx_reset_q   <= cmd[`SPCM_CMD_RXRST]; // R12
            lin_wakeup_q <= cmd[`SPCM_CMD_LINWAKE]; // R1
            lin_abort_q  <= cmd[`SPCM_CMD_LINABORT]; // R2
            // deassert wins if both bits land together
            if (cmd[`SPCM_CMD_REQDEASSERT])
                rts_q <= 1'b1; // R3
            else if (cmd[`SPCM_CMD_REQASSERT])
                rts_q <= 1'b0; // R4
        end
    end

    // error flags: err_q injected through a test register, flag_a from flag_a_seen, set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_q       <= 8'h00;
            flag_a_flag_q <= 1'b0;
        end else begin
            err_q <= (cmd[`SPCM_CMD_STCLR] ? 8'h00 : err_q) | // R10
                ((wr_go && awaddr_q == `SPCM_OFF_ERRINJ) ? wdata_q[7:0] : 8'h00);
            if (flag_a_seen && flag_a_enable_q)
                flag_a_flag_q <= 1'b1; // R14
            else if (cmd[`SPCM_CMD_NACKCLR])
                flag_a_flag_q <= 1'b0; // R14
        end
    end

    // receiver timeout: counts timeout_tick pulses
    always @(posedge aclk) begin
        if (!aresetn) begin
            to_cnt_q       <= 16'h0000;
            to_run_q       <= 1'b0;
            to_wait_q      <= 1'b0;
            timeout_flag_q <= 1'b0;
        end else if (cmd[`SPCM_CMD_TOREARM]) begin
            to_cnt_q       <= `SPCM_TO_RELOAD; // R5
            to_run_q       <= 1'b1; // R5
            to_wait_q      <= 1'b0;
            timeout_flag_q <= 1'b0; // R5
        end else if (cmd[`SPCM_CMD_TOSTART]) begin
            to_run_q       <= 1'b0; // R6
            to_wait_q      <= 1'b1; // R6
            timeout_flag_q <= 1'b0; // R6
        end else begin
            if (to_wait_q && rx_char_done) begin
                to_wait_q <= 1'b0; // R6
                to_run_q  <= 1'b1;
                to_cnt_q  <= `SPCM_TO_RELOAD;
            end else if (to_run_q && timeout_tick) begin
                if (to_cnt_q == 16'h0001) begin
                    to_run_q       <= 1'b0;
                    timeout_flag_q <= 1'b1;
                end
                to_cnt_q <= to_cnt_q - 16'h0001;
            end
        end
    end

    // break sequencing and address marking of the next held character
    always @(posedge aclk) begin
        if (!aresetn) begin
            brk_pend_q     <= 1'b0;
            break_active_q <= 1'b0;
            guard_active_q <= 1'b0;
            guard_cnt_q    <= 8'h00;
            send_address_q <= 1'b0;
            addr_mark_q    <= 1'b0;
            tx_load_q      <= 1'b0;
            tx_char_q      <= 9'h000;
        end else begin
            if (cmd[`SPCM_CMD_BRKSTART] && !break_active_q)
                brk_pend_q <= 1'b1; // R9
            if (brk_pend_q && tx_drained && !break_active_q) begin
                brk_pend_q     <= 1'b0; // R9
                break_active_q <= 1'b1; // R9
            end
            if (cmd[`SPCM_CMD_BRKSTOP] && break_active_q) begin
                break_active_q <= 1'b0; // R8
                guard_active_q <= 1'b1; // R8
                // guard lasts the longer of timeguard and the minimum bits
                guard_cnt_q <= (timeguard_length_q > `SPCM_GUARD_MIN_BITS) ?
                    timeguard_length_q : `SPCM_GUARD_MIN_BITS; // R8
            end else if (guard_active_q && tx_bit_tick) begin
                if (guard_cnt_q == 8'h01)
                    guard_active_q <= 1'b0;
                guard_cnt_q <= guard_cnt_q - 8'h01;
            end
            tx_load_q <= wr_go && awaddr_q == `SPCM_OFF_TXHOLD;
            if (wr_go && awaddr_q == `SPCM_OFF_TXHOLD) begin
                tx_char_q      <= wdata_q[8:0];
                addr_mark_q    <= send_address_q && parity_mode_q == 3'h5; // R7
                send_address_q <= 1'b0;
            end else if (cmd[`SPCM_CMD_SENDADDR]) begin
                send_address_q <= 1'b1; // R7
            end
        end
    end

    // mode register decode into registered line controls
    always @(posedge aclk) begin
        if (!aresetn) begin
            clk_pin_oe_q    <= 1'b0;
            clk_idle_q      <= 1'b0;
            msb_first_q     <= 1'b0;
            over8_q         <= 1'b0;
            char_bits_q     <= 4'h5;
            loop_mode_q     <= 2'h0;
            stop_code_q     <= 2'h0;
            stop_reserved_q <= 1'b0;
            parity_mode_q   <= 3'h0;
            sync_or_phase_q <= 1'b0;
            flag_a_enable_q   <= 1'b1;
        end else begin
            flag_a_enable_q <= !mode_q[20]; // R14
            over8_q       <= mode_q[19]; // R15
            clk_pin_oe_q  <= mode_q[18] && mode_q[5:4] != `SPCM_CLKSRC_EXT; // R16
            char_bits_q   <= mode_q[17] ? 4'h9 : {2'h0, mode_q[7:6]} + 4'h5; // R17
            msb_first_q   <= !spi && mode_q[16]; // R18
            clk_idle_q    <= spi && mode_q[16]; // R18
            loop_mode_q   <= mode_q[15:14]; // R19
            stop_code_q   <= mode_q[13:12]; // R20
            stop_reserved_q <= (mode_q[13:12] == 2'h3) ||
                (mode_q[13:12] == 2'h1 && mode_q[8] && !spi); // R20
            case (mode_q[11:9]) // R21
                3'h0, 3'h1, 3'h2, 3'h3: parity_mode_q <= {1'b0, mode_q[10:9]};
                3'h4, 3'h5: parity_mode_q <= 3'h4;
                default: parity_mode_q <= 3'h5;
            endcase
            sync_or_phase_q <= mode_q[8]; // R22
        end
    end

    // select and rts share one pin, so spi master needs no separate path
    wire unused_ok = spi_m;

endmodule

/* test/spcm_remote_node.sv */
// line-side node model feeding bit ticks and character events
`timescale 1ns/1ps
module spcm_remote_node (
    input  wire aclk,
    input  wire aresetn,
    input  wire busy,
    output reg  rx_char_done,
    output wire tx_drained,
    output reg  tx_bit_tick,
    output reg  flag_a_seen,
    output reg  timeout_tick
);
    reg [5:0] cyc_q;
    // shift path idle only when the bench lets it drain
    assign tx_drained = !busy;
    // fast bit period keeps guard counts short
    always @(posedge aclk) begin
        cyc_q <= aresetn ? cyc_q + 6'h01 : 6'h00;
        tx_bit_tick <= aresetn && cyc_q[1:0] == 2'h3;
        timeout_tick <= aresetn && cyc_q[1:0] == 2'h1;
        rx_char_done <= aresetn && cyc_q == 6'h3f;
        flag_a_seen <= aresetn && cyc_q == 6'h20;
    end
endmodule

/* test/spcm_chk.sv */
// port assertions for the serial port control block
`timescale 1ns/1ps
module spcm_chk (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    input wire [1:0] s_axi_rresp,
    input wire       tx_drained,
    input wire       tx_bit_tick,
    input wire       lin_wakeup_q,
    input wire       tx_reset_q,
    input wire       break_active_q,
    input wire       guard_active_q,
    input wire [3:0] char_bits_q,
    input wire [1:0] stop_code_q,
    input wire       stop_reserved_q,
    input wire [2:0] parity_mode_q
);
    reg [7:0] ticks_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ticks seen while the guard ones are sent
    always @(posedge aclk)
        ticks_q <= guard_active_q ? ticks_q + {7'h00, tx_bit_tick} : 8'h00;
    a_wake_pulse: assert property (lin_wakeup_q |=> !lin_wakeup_q)
        else $error("wakeup pulse too long");
    a_txrst_pulse: assert property (tx_reset_q |=> !tx_reset_q)
        else $error("transmit reset pulse too long");
    a_break_drained: assert property ($rose(break_active_q) |-> $past(tx_drained))
        else $error("break began before transmit drained");
    a_guard_follows: assert property ($rose(guard_active_q) |-> $past(break_active_q))
        else $error("guard began without a break");
    a_guard_min: assert property ($fell(guard_active_q) |-> ticks_q >= 8'h0c)
        else $error("guard shorter than twelve bits");
    a_char_range: assert property (char_bits_q >= 4'h5 && char_bits_q <= 4'h9)
        else $error("character length out of range");
    a_stop_res: assert property (stop_code_q == 2'h3 |-> stop_reserved_q)
        else $error("stop code three not reserved");
    a_par_range: assert property (parity_mode_q <= 3'h5)
        else $error("parity mode out of range");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    c_guard: cover property ($rose(guard_active_q));
    c_wake: cover property (lin_wakeup_q);
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind spcm_top spcm_chk spcm_chk_inst (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .tx_drained, .tx_bit_tick,
    .lin_wakeup_q, .tx_reset_q, .break_active_q, .guard_active_q, .char_bits_q, .stop_code_q,
    .stop_reserved_q, .parity_mode_q);

/* test/tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb;
    reg aclk = 1'h0, aresetn = 1'h0, busy = 1'h1, clr = 1'h0;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'h0;
    reg [4:0] pseen;
    reg [7:0] gseen;
    wire [31:0] s_axi_rdata;
    wire [1:0] s_axi_bresp, s_axi_rresp, loop_mode_q, stop_code_q;
    wire [8:0] tx_char_q;
    wire [3:0] char_bits_q;
    wire [2:0] parity_mode_q;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire rx_char_done, tx_drained, tx_bit_tick, flag_a_seen, timeout_tick, tx_enabled_q;
    wire rx_enabled_q, tx_reset_q, rx_reset_q, lin_wakeup_q, lin_abort_q, rts_q;
    wire break_active_q, guard_active_q, addr_mark_q, tx_load_q, clk_pin_oe_q, clk_idle_q;
    wire msb_first_q, over8_q, stop_reserved_q, sync_or_phase_q, flag_a_enable_q;
    integer errors = 0, tests_run = 0;
    spcm_top spcm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_char_done, .tx_drained, .tx_bit_tick,
        .flag_a_seen, .timeout_tick, .tx_enabled_q, .rx_enabled_q, .tx_reset_q, .rx_reset_q,
        .lin_wakeup_q, .lin_abort_q, .rts_q, .break_active_q, .guard_active_q, .addr_mark_q,
        .tx_load_q, .tx_char_q, .clk_pin_oe_q, .clk_idle_q, .msb_first_q, .over8_q,
        .char_bits_q, .loop_mode_q, .stop_code_q, .stop_reserved_q, .parity_mode_q,
        .sync_or_phase_q, .flag_a_enable_q);
    spcm_remote_node spcm_remote_node_inst (.aclk, .aresetn, .busy, .rx_char_done,
        .tx_drained, .tx_bit_tick, .flag_a_seen, .timeout_tick);
    always #25 aclk = !aclk;
    // sticky record so one-cycle pulses are never missed
    always @(posedge aclk)
        pseen <= clr ? 5'h00 : pseen | {tx_load_q, lin_abort_q, lin_wakeup_q, rx_reset_q,
            tx_reset_q};
    // guard bit ticks counted from the very first edge of the guard
    always @(posedge aclk)
        gseen <= clr ? 8'h00 : gseen + {7'h00, guard_active_q & tx_bit_tick};
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input [8*12-1:0] name);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                $display("Error %0s expected %h seen %h", name, exp, seen);
                errors = errors + 1;
            end
        end
    endtask
    task tmo(input integer i);
        if (i == 50) begin
            errors = errors + 1;
            stop_test;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        integer i;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            for (i = 0; i < 50; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
                if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
                if (s_axi_bvalid === 1'h1) begin
                    r = s_axi_bresp;
                    s_axi_bready <= 1'h0;
                    i = 99;
                end
            end
            tmo(i);
            @(posedge aclk);
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        integer i;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            for (i = 0; i < 50; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
                if (s_axi_rvalid === 1'h1) begin
                    d = s_axi_rdata;
                    r = s_axi_rresp;
                    s_axi_rready <= 1'h0;
                    i = 99;
                end
            end
            tmo(i);
            @(posedge aclk);
        end
    endtask
    task t_regs;
        reg [31:0] d;
        reg [1:0] r;
        begin
            chk(rts_q, 1, "rts_reset");
            chk(tx_enabled_q, 0, "tx_reset");
            rd(8'h04, d, r);
            chk(d, 0, "mode_reset");
            wr(8'h20, 32'h1, r);
            chk(r, 2, "wr_unmapped");
            rd(8'h20, d, r);
            chk(r, 2, "rd_unmapped");
            chk(d, 0, "rd_unm_data");
            $display("registers done");
        end
    endtask
    task t_mode;
        reg [31:0] w, d;
        reg [1:0] r;
        integer k;
        begin
            for (k = 0; k < 12; k = k + 1) begin
                w = {32'h001fffff, 32'h000a5b31, 32'h0006e9ce, 32'h00113580} >> (32 * k);
                if (k > 3) w = ((k - 4) << 9) | ((k & 3) * 32'h5040);
                wr(8'h04, w, r);
                rd(8'h04, d, r);
                chk(d, w & 32'h001fffff, "mode_read");
                chk(over8_q, w[19], "over8");
                chk(char_bits_q, w[17] ? 9 : 5 + w[7:6], "char_bits");
                chk(loop_mode_q, w[15:14], "loop_mode");
                chk(stop_code_q, w[13:12], "stop_code");
                chk(parity_mode_q, w[11] ? 4 + w[10] : w[11:9], "parity");
                chk(sync_or_phase_q, w[8], "sync_phase");
                chk(flag_a_enable_q, !w[20], "flag_a_en");
                chk(clk_pin_oe_q, w[18] && w[5:4] != 2'h3, "clk_oe");
                if (w[3:1] == 3'h7) chk(clk_idle_q, w[16], "clk_idle");
                else chk(msb_first_q, w[16], "msb_first");
                if (w[3:1] != 3'h7) chk(stop_reserved_q, &w[13:12] | w[12] & w[8], "stop_res");
            end
            wr(8'h10, 32'h1, r);
            wr(8'h04, 32'h000000c0, r);
            chk(r, 2, "wp_resp");
            rd(8'h04, d, r);
            chk(d, w, "wp_keep");
            wr(8'h10, 32'h0, r);
            $display("mode done");
        end
    endtask
    task t_cmds;
        reg [55:0] seq;
        reg [1:0] r;
        integer k;
        begin
            seq = 56'h50f050a05030c0;
            for (k = 0; k < 7; k = k + 1) begin
                wr(8'h00, seq[55 - 8 * k -: 8], r);
                @(posedge aclk);
                chk({tx_enabled_q, rx_enabled_q}, 14'h3338 >> (12 - 2 * k) & 3, "enables");
            end
            for (k = 0; k < 4; k = k + 1) begin
                wr(8'h00, (8'h9d >> (2 * k) & 3) << 18, r);
                @(posedge aclk);
                chk(rts_q, k & 1, "rts");
            end
            for (k = 0; k < 4; k = k + 1) begin
                clr <= 1'h1;
                @(posedge aclk);
                clr <= 1'h0;
                wr(8'h00, 32'h0, r);
                repeat (3) @(posedge aclk);
                chk(pseen, 0, "zero_write");
                wr(8'h00, 32'h1 << (k < 2 ? 3 - k : 23 - k), r);
                repeat (3) @(posedge aclk);
                chk(pseen, 1 << k, "pulses");
            end
            $display("commands done");
        end
    endtask
    task t_break;
        reg [1:0] r;
        integer k, i;
        begin
            for (k = 0; k < 2; k = k + 1) begin
                wr(8'h10, k * 40, r);
                busy <= 1'h1;
                wr(8'h00, 32'h200, r);
                repeat (8) @(posedge aclk);
                chk(break_active_q, 0, "brk_wait");
                busy <= 1'h0;
                repeat (4) @(posedge aclk);
                chk(break_active_q, 1, "brk_on");
                clr <= 1'h1;
                @(posedge aclk);
                clr <= 1'h0;
                wr(8'h00, 32'h400, r);
                for (i = 0; i < 400 && guard_active_q === 1'h1; i = i + 1) @(posedge aclk);
                chk(gseen, k ? 20 : 12, "guard_bits");
                chk(break_active_q, 0, "brk_off");
            end
            wr(8'h00, 32'h400, r);
            repeat (3) @(posedge aclk);
            chk(guard_active_q, 0, "stop_idle");
            $display("break done");
        end
    endtask
    task t_addr;
        reg [31:0] d;
        reg [1:0] r;
        integer k;
        begin
            wr(8'h04, 32'h00000cc0, r);
            wr(8'h00, 32'h1000, r);
            for (k = 0; k < 2; k = k + 1) begin
                clr <= 1'h1;
                @(posedge aclk);
                clr <= 1'h0;
                wr(8'h0c, k ? 32'h05a : 32'h1a5, r);
                chk(pseen[4], 1, "tx_load");
                chk({addr_mark_q, tx_char_q}, k ? 10'h05a : 10'h3a5, "addr_char");
            end
            wr(8'h14, 32'hff, r);
            rd(8'h08, d, r);
            chk(d[7:0], 8'hff, "err_set");
            wr(8'h00, 32'h100, r);
            rd(8'h08, d, r);
            chk(d[7:0], 8'h00, "err_clear");
            $display("address and status done");
        end
    endtask
    task t_tmo;
        reg [31:0] d;
        reg [1:0] r;
        begin
            wr(8'h00, 32'h8000, r);
            rd(8'h08, d, r);
            chk({d[11], d[9:8]}, 3'h2, "to_rearm");
            repeat (1100) @(posedge aclk);
            rd(8'h08, d, r);
            chk({d[11], d[9:8]}, 3'h4, "to_expire");
            wr(8'h00, 32'h800, r);
            rd(8'h08, d, r);
            chk(d[11], 0, "to_clear");
            // a character arrives every 64 cycles and starts the count
            repeat (70) @(posedge aclk);
            rd(8'h08, d, r);
            chk({d[11], d[9:8]}, 3'h2, "to_restart");
            $display("timeout done");
        end
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs;
        t_mode;
        t_cmds;
        t_break;
        t_addr;
        t_tmo;
        stop_test;
    end
endmodule
